// ### src/lcb_regs.sv
// configuration and group-control register bank with per-module source selection
// assumes the serial protocol engine drives the register port on core_clk
module lcb_regs (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [lcb_pkg::LCB_AW-1:0] reg_addr,
    input wire logic [lcb_pkg::LCB_DW-1:0] reg_wr_data,
    output logic [lcb_pkg::LCB_DW-1:0] reg_rd_data,
    output logic reg_rd_valid,
    output logic chip_enable,
    output logic log_scale_en,
    output logic power_save_en,
    output logic auto_incr_en,
    output logic dither_en,
    output logic max_current_sel,
    output logic all_outputs_off,
    output logic [lcb_pkg::LCB_NUM_MODULES-1:0] module_group_select,
    output logic [lcb_pkg::LCB_DW-1:0] group_intensity,
    output logic [lcb_pkg::LCB_DW-1:0] group_mix_first,
    output logic [lcb_pkg::LCB_DW-1:0] group_mix_second,
    output logic [lcb_pkg::LCB_DW-1:0] group_mix_third,
    input wire logic [lcb_pkg::LCB_NUM_MODULES*lcb_pkg::LCB_DW-1:0] own_bright,
    input wire logic [lcb_pkg::LCB_NUM_MODULES*lcb_pkg::LCB_NUM_COLORS*lcb_pkg::LCB_DW-1:0] own_color,
    output logic [lcb_pkg::LCB_NUM_MODULES*lcb_pkg::LCB_DW-1:0] eff_bright,
    output logic [lcb_pkg::LCB_NUM_MODULES*lcb_pkg::LCB_NUM_COLORS*lcb_pkg::LCB_DW-1:0] eff_color
);
    import lcb_pkg::*;

    localparam int CW = LCB_NUM_COLORS * LCB_DW;

    logic [LCB_DW-1:0] dev_ctrl_r;
    logic [LCB_DW-1:0] glob_r;
    logic [LCB_DW-1:0] grp_sel_r;
    logic [LCB_DW-1:0] grp_int_r;
    logic [LCB_DW-1:0] mix0_r;
    logic [LCB_DW-1:0] mix1_r;
    logic [LCB_DW-1:0] mix2_r;
    logic [LCB_DW-1:0] rd_data_r;
    logic [LCB_DW-1:0] rd_data_nxt;
    logic rd_valid_r;
    logic wr_hit;
    logic force_off;

    assign wr_hit = clk_en && reg_wr_en;

    // device enable register, all bits stored
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dev_ctrl_r <= LCB_RST_DEVICE_ENABLE_CTRL;
        end else if (wr_hit && reg_addr == LCB_ADDR_DEVICE_ENABLE_CTRL) begin
            dev_ctrl_r <= reg_wr_data;
        end
    end

    // global settings register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            glob_r <= LCB_RST_GLOBAL_SETTINGS;
        end else if (wr_hit && reg_addr == LCB_ADDR_GLOBAL_SETTINGS) begin
            glob_r <= reg_wr_data;
        end
    end

    // group mode select register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            grp_sel_r <= LCB_RST_GROUP_MODE_SELECT;
        end else if (wr_hit && reg_addr == LCB_ADDR_GROUP_MODE_SELECT) begin
            grp_sel_r <= reg_wr_data;
        end
    end

    // group intensity register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            grp_int_r <= LCB_RST_GROUP_INTENSITY;
        end else if (wr_hit && reg_addr == LCB_ADDR_GROUP_INTENSITY) begin
            grp_int_r <= reg_wr_data;
        end
    end

    // three group colour-mix registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mix0_r <= LCB_RST_GROUP_MIX;
            mix1_r <= LCB_RST_GROUP_MIX;
            mix2_r <= LCB_RST_GROUP_MIX;
        end else if (wr_hit) begin
            if (reg_addr == LCB_ADDR_GROUP_MIX_FIRST) begin
                mix0_r <= reg_wr_data;
            end
            if (reg_addr == LCB_ADDR_GROUP_MIX_SECOND) begin
                mix1_r <= reg_wr_data;
            end
            if (reg_addr == LCB_ADDR_GROUP_MIX_THIRD) begin
                mix2_r <= reg_wr_data;
            end
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        case (reg_addr)
            LCB_ADDR_DEVICE_ENABLE_CTRL: rd_data_nxt = dev_ctrl_r;
            LCB_ADDR_GLOBAL_SETTINGS: rd_data_nxt = glob_r;
            LCB_ADDR_GROUP_MODE_SELECT: rd_data_nxt = grp_sel_r;
            LCB_ADDR_GROUP_INTENSITY: rd_data_nxt = grp_int_r;
            LCB_ADDR_GROUP_MIX_FIRST: rd_data_nxt = mix0_r;
            LCB_ADDR_GROUP_MIX_SECOND: rd_data_nxt = mix1_r;
            LCB_ADDR_GROUP_MIX_THIRD: rd_data_nxt = mix2_r;
            default: rd_data_nxt = LCB_UNMAPPED_READ;
        endcase
    end

    // read answer one cycle after the request, held until the next read
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_r <= LCB_RST_READ_DATA;
            rd_valid_r <= 1'b0;
        end else if (clk_en) begin
            rd_valid_r <= reg_rd_en;
            if (reg_rd_en) begin
                rd_data_r <= rd_data_nxt;
            end
        end
    end

    // outputs taken straight from register bits
    assign reg_rd_data = rd_data_r;
    assign reg_rd_valid = rd_valid_r;
    assign chip_enable = dev_ctrl_r[LCB_BIT_CHIP_ENABLE];
    assign log_scale_en = glob_r[LCB_BIT_LOG_SCALE];
    assign power_save_en = glob_r[LCB_BIT_POWER_SAVE];
    assign auto_incr_en = glob_r[LCB_BIT_AUTO_INCR];
    assign dither_en = glob_r[LCB_BIT_DITHER];
    assign max_current_sel = glob_r[LCB_BIT_MAX_CURRENT];
    assign all_outputs_off = glob_r[LCB_BIT_ALL_OFF];
    assign module_group_select = grp_sel_r;
    assign group_intensity = grp_int_r;
    assign group_mix_first = mix0_r;
    assign group_mix_second = mix1_r;
    assign group_mix_third = mix2_r;

    // a disabled device or a global off blanks every module
    assign force_off = glob_r[LCB_BIT_ALL_OFF] || !dev_ctrl_r[LCB_BIT_CHIP_ENABLE];

    // one selector per rgb module
    for (genvar n = 0; n < LCB_NUM_MODULES; n++) begin : g_mod
        lcb_mix u_mix (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .clk_en(clk_en),
            .group_sel(grp_sel_r[n]),
            .force_off(force_off),
            .grp_bright(grp_int_r),
            .grp_mix0(mix0_r),
            .grp_mix1(mix1_r),
            .grp_mix2(mix2_r),
            .own_bright(own_bright[n*LCB_DW +: LCB_DW]),
            .own_color(own_color[n*CW +: CW]),
            .eff_bright_r(eff_bright[n*LCB_DW +: LCB_DW]),
            .eff_color_r(eff_color[n*CW +: CW])
        );
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // write strobe to one offset, in a single cycle
    sequence s_wr(logic [7:0] a);
        clk_en && reg_wr_en && reg_addr == a;
    endsequence

    property p_chip_en;
        s_wr(LCB_ADDR_DEVICE_ENABLE_CTRL) |=> chip_enable == $past(reg_wr_data[6]);
    endproperty
    a_chip_en: assert property (p_chip_en) else $error("chip enable not written");

    property p_log_scale;
        s_wr(LCB_ADDR_GLOBAL_SETTINGS) |=> log_scale_en == $past(reg_wr_data[5]);
    endproperty
    a_log_scale: assert property (p_log_scale) else $error("log scale bit wrong");

    property p_power_save;
        s_wr(LCB_ADDR_GLOBAL_SETTINGS) |=> power_save_en == $past(reg_wr_data[4]);
    endproperty
    a_power_save: assert property (p_power_save) else $error("power save bit wrong");

    property p_auto_incr;
        s_wr(LCB_ADDR_GLOBAL_SETTINGS) |=> auto_incr_en == $past(reg_wr_data[3]);
    endproperty
    a_auto_incr: assert property (p_auto_incr) else $error("auto increment bit wrong");

    property p_dither;
        s_wr(LCB_ADDR_GLOBAL_SETTINGS) |=> dither_en == $past(reg_wr_data[2]);
    endproperty
    a_dither: assert property (p_dither) else $error("dither bit wrong");

    property p_max_cur;
        s_wr(LCB_ADDR_GLOBAL_SETTINGS) |=> max_current_sel == $past(reg_wr_data[1]);
    endproperty
    a_max_cur: assert property (p_max_cur) else $error("current range bit wrong");

    property p_all_off;
        all_outputs_off && clk_en |=> eff_bright == '0 && eff_color == '0;
    endproperty
    a_all_off: assert property (p_all_off) else $error("outputs not forced off");

    property p_grp_sel;
        s_wr(LCB_ADDR_GROUP_MODE_SELECT) |=> module_group_select == $past(reg_wr_data);
    endproperty
    a_grp_sel: assert property (p_grp_sel) else $error("group select wrong");

    property p_intensity;
        s_wr(LCB_ADDR_GROUP_INTENSITY) ##1 !reg_wr_en |=> group_intensity == $past(reg_wr_data, 2);
    endproperty
    a_intensity: assert property (p_intensity) else $error("intensity not held");

    property p_mix;
        s_wr(LCB_ADDR_GROUP_MIX_THIRD) |=> group_mix_third == $past(reg_wr_data)
            && $stable(group_mix_first);
    endproperty
    a_mix: assert property (p_mix) else $error("mix value wrong");

    sequence s_rd;
        clk_en && reg_rd_en && !reg_wr_en && reg_addr == LCB_ADDR_GLOBAL_SETTINGS;
    endsequence
    property p_readback;
        s_rd |=> reg_rd_valid && reg_rd_data == $past(glob_r);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

    // read valid drops one cycle after a cycle with clk_en high and no read request; while clk_en is low it holds
    property p_rd_pulse;
        clk_en && !reg_rd_en |=> !reg_rd_valid;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read valid held too long");

    property p_group_use;
        clk_en && grp_sel_r[0] && !force_off |=> eff_bright[7:0] == $past(grp_int_r)
            && eff_color[7:0] == $past(mix0_r) && eff_color[15:8] == $past(mix1_r)
            && eff_color[23:16] == $past(mix2_r);
    endproperty
    a_group_use: assert property (p_group_use) else $error("group values not used");
endmodule

// ### src/lcb_pkg.sv
// constants for the configuration and group-control register bank of an rgb led driver
// assumes one clock domain shared with the serial protocol engine that drives the register port
//
// Contract
// - bit 6 of device_enable_ctrl enables the device; clear means disabled; resets 0.
// - global_settings bit 5 selects logarithmic (1) or linear (0) dimming; resets 1.
// - global_settings bit 4 enables automatic power-saving entry; resets 1.
// - global_settings bit 3 enables register address auto-increment; resets 1.
// - global_settings bit 2 enables pwm dithering on outputs; resets 1.
// - global_settings bit 1 selects 35 mA (1) or 25.5 mA (0) range; resets 0.
// - global_settings bit 0 forces every led output off; zero resumes; resets 0.
// - group_mode_select bit n puts module n under group control; resets 0.
// - group_intensity scales brightness linearly by code; resets to all ones.
// - three group colour-mix values scale mixing linearly by code; each resets 0.
// - every bit, reserved included, reads and writes; all return reset values.
package lcb_pkg;
    localparam int LCB_DW = 8;
    localparam int LCB_AW = 8;
    localparam int LCB_NUM_REGS = 7;
    localparam int LCB_NUM_MODULES = 8;
    localparam int LCB_NUM_COLORS = 3;

    // register offsets
    localparam logic [7:0] LCB_ADDR_DEVICE_ENABLE_CTRL = 8'h00;
    localparam logic [7:0] LCB_ADDR_GLOBAL_SETTINGS = 8'h01;
    localparam logic [7:0] LCB_ADDR_GROUP_MODE_SELECT = 8'h02;
    localparam logic [7:0] LCB_ADDR_GROUP_INTENSITY = 8'h03;
    localparam logic [7:0] LCB_ADDR_GROUP_MIX_FIRST = 8'h04;
    localparam logic [7:0] LCB_ADDR_GROUP_MIX_SECOND = 8'h05;
    localparam logic [7:0] LCB_ADDR_GROUP_MIX_THIRD = 8'h06;

    // reset values
    localparam logic [7:0] LCB_RST_DEVICE_ENABLE_CTRL = 8'h00;
    localparam logic [7:0] LCB_RST_GLOBAL_SETTINGS = 8'h3C;
    localparam logic [7:0] LCB_RST_GROUP_MODE_SELECT = 8'h00;
    localparam logic [7:0] LCB_RST_GROUP_INTENSITY = 8'hFF;
    localparam logic [7:0] LCB_RST_GROUP_MIX = 8'h00;
    localparam logic [7:0] LCB_RST_READ_DATA = 8'h00;

    // field positions
    localparam int LCB_BIT_CHIP_ENABLE = 6;
    localparam int LCB_BIT_LOG_SCALE = 5;
    localparam int LCB_BIT_POWER_SAVE = 4;
    localparam int LCB_BIT_AUTO_INCR = 3;
    localparam int LCB_BIT_DITHER = 2;
    localparam int LCB_BIT_MAX_CURRENT = 1;
    localparam int LCB_BIT_ALL_OFF = 0;

    // value shown for an unmapped read
    localparam logic [7:0] LCB_UNMAPPED_READ = 8'h00;
endpackage

// ### src/lcb_mix.sv
// one rgb module's source selection: group values or its own settings
// assumes all inputs come from flip-flops on core_clk
module lcb_mix (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic group_sel,
    input wire logic force_off,
    input wire logic [lcb_pkg::LCB_DW-1:0] grp_bright,
    input wire logic [lcb_pkg::LCB_DW-1:0] grp_mix0,
    input wire logic [lcb_pkg::LCB_DW-1:0] grp_mix1,
    input wire logic [lcb_pkg::LCB_DW-1:0] grp_mix2,
    input wire logic [lcb_pkg::LCB_DW-1:0] own_bright,
    input wire logic [lcb_pkg::LCB_NUM_COLORS*lcb_pkg::LCB_DW-1:0] own_color,
    output logic [lcb_pkg::LCB_DW-1:0] eff_bright_r,
    output logic [lcb_pkg::LCB_NUM_COLORS*lcb_pkg::LCB_DW-1:0] eff_color_r
);
    import lcb_pkg::*;

    logic [LCB_DW-1:0] bright_nxt;
    logic [LCB_NUM_COLORS*LCB_DW-1:0] color_nxt;

    // pick group or own values; forced off blanks everything
    always_comb begin
        if (force_off) begin
            bright_nxt = '0;
            color_nxt = '0;
        end else if (group_sel) begin
            bright_nxt = grp_bright;
            color_nxt = {grp_mix2, grp_mix1, grp_mix0};
        end else begin
            bright_nxt = own_bright;
            color_nxt = own_color;
        end
    end

    // registered so the top's outputs come from flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            eff_bright_r <= '0;
            eff_color_r <= '0;
        end else if (clk_en) begin
            eff_bright_r <= bright_nxt;
            eff_color_r <= color_nxt;
        end
    end
endmodule

// ### test/lcb_host.sv
// partner model: the serial protocol engine side of the register strobe port
// assumes the bench calls its tasks only after reset has been released
module lcb_host (
    input wire logic core_clk,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [lcb_pkg::LCB_AW-1:0] reg_addr,
    output logic [lcb_pkg::LCB_DW-1:0] reg_wr_data,
    input wire logic [lcb_pkg::LCB_DW-1:0] reg_rd_data,
    input wire logic reg_rd_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    import lcb_pkg::*;

    // idle port at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wr_data = 8'h00;
    end

    // one byte written; address and data are inverted once released so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wr_data <= ~d;
    endtask

    // one byte read; the answer is awaited for a few edges at most
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int i;
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        ok = 1'b0;
        d = 8'h00;
        for (i = 0; i < 4 && !ok; i++) begin
            @(posedge core_clk);
            if (reg_rd_valid === 1'b1) begin
                ok = 1'b1;
                d = reg_rd_data;
            end
        end
    endtask
endmodule

// ### test/lcb_regs_tb.sv
// self-checking bench for the register bank and its per-module source selection
// assumes lcb_host stands in for the serial engine; own_* are driven here directly
module lcb_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lcb_pkg::*;

    logic core_clk, rst_b, clk_en, reg_wr_en, reg_rd_en, reg_rd_valid, ok;
    logic chip_enable, log_scale_en, power_save_en, auto_incr_en, dither_en;
    logic max_current_sel, all_outputs_off;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, rv, wv, module_group_select;
    logic [7:0] group_intensity, group_mix_first, group_mix_second, group_mix_third;
    logic [63:0] own_bright, eff_bright, exp_b;
    logic [191:0] own_color, eff_color, exp_c;
    logic [7:0] rst_tab [7] = '{8'h00, 8'h3C, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    int miscompares, checks, i, n, k;

    lcb_regs dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .chip_enable(chip_enable), .log_scale_en(log_scale_en),
        .power_save_en(power_save_en), .auto_incr_en(auto_incr_en), .dither_en(dither_en),
        .max_current_sel(max_current_sel), .all_outputs_off(all_outputs_off),
        .module_group_select(module_group_select), .group_intensity(group_intensity),
        .group_mix_first(group_mix_first), .group_mix_second(group_mix_second),
        .group_mix_third(group_mix_third), .own_bright(own_bright), .own_color(own_color),
        .eff_bright(eff_bright), .eff_color(eff_color));

    lcb_host host (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid));

    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // verdict and end of run
    task automatic conclude();
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one comparison, counted
    task automatic chk(input logic [191:0] got, input logic [191:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // read one byte and compare; a missing answer ends the run
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rv, ok);
        if (!ok) begin
            miscompares++;
            $display("ERROR %0t no read answer", $time);
            conclude();
        end else begin
            chk(rv, exp, "read data");
        end
    endtask

    // six global setting pins, bit 5 down to bit 0
    function automatic logic [5:0] gbits();
        return {log_scale_en, power_save_en, auto_incr_en, dither_en, max_current_sel,
            all_outputs_off};
    endfunction

    // hang guard
    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        $display("ERROR %0t run did not finish", $time);
        conclude();
    end

    // main sequence
    initial begin
        miscompares = 0;
        checks = 0;
        rst_b = 1'b0;
        clk_en = 1'b1;
        own_bright = '0;
        own_color = '0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        chk({chip_enable, gbits()}, {rst_tab[0][6], rst_tab[1][5:0]}, "reset pins");
        chk({module_group_select, group_intensity}, {rst_tab[2], rst_tab[3]}, "reset grp");
        chk({group_mix_first, group_mix_second, group_mix_third}, 24'h0, "reset mix");
        // unmapped write must land nowhere, unmapped read answers the fixed value
        host.wr(8'h07, 8'h5A);
        rchk(8'h07, LCB_UNMAPPED_READ);
        for (i = 0; i < 7; i++) begin
            rchk(8'(i), rst_tab[i]);
        end
        // every bit of every register holds both values, reserved bits included
        for (i = 0; i < 7; i++) begin
            wv = 8'(8'hA5 + i * 8'h13);
            host.wr(8'(i), wv);
            rchk(8'(i), wv);
            host.wr(8'(i), ~wv);
            rchk(8'(i), ~wv);
        end
        // each global setting alone reaches its own pin
        for (i = 0; i < 6; i++) begin
            host.wr(LCB_ADDR_GLOBAL_SETTINGS, 8'h01 << i);
            @(posedge core_clk);
            chk(gbits(), 6'h01 << i, "global bit");
        end
        host.wr(LCB_ADDR_DEVICE_ENABLE_CTRL, 8'h40);
        @(posedge core_clk);
        chk(chip_enable, 1'b1, "enable set");
        host.wr(LCB_ADDR_DEVICE_ENABLE_CTRL, 8'hBF);
        @(posedge core_clk);
        chk(chip_enable, 1'b0, "enable clear");
        // own settings differ from group values so the chosen source shows
        for (n = 0; n < 8; n++) begin
            own_bright[8*n+:8] <= 8'(8'h10 + n);
            for (k = 0; k < 3; k++) begin
                own_color[24*n+8*k+:8] <= 8'(n * 8'h10 + k + 1);
            end
        end
        host.wr(LCB_ADDR_DEVICE_ENABLE_CTRL, 8'h40);
        host.wr(LCB_ADDR_GLOBAL_SETTINGS, 8'h00);
        host.wr(LCB_ADDR_GROUP_MODE_SELECT, 8'hA5);
        host.wr(LCB_ADDR_GROUP_INTENSITY, 8'h80);
        host.wr(LCB_ADDR_GROUP_MIX_FIRST, 8'h11);
        host.wr(LCB_ADDR_GROUP_MIX_SECOND, 8'h22);
        host.wr(LCB_ADDR_GROUP_MIX_THIRD, 8'h33);
        repeat (2) @(posedge core_clk);
        for (n = 0; n < 8; n++) begin
            exp_b[8*n+:8] = (n == 0 || n == 2 || n == 5 || n == 7) ? 8'h80 : own_bright[8*n+:8];
            exp_c[24*n+:24] = exp_b[8*n+:8] == 8'h80 ? 24'h332211 : own_color[24*n+:24];
        end
        chk(eff_bright, exp_b, "eff bright");
        chk(eff_color, exp_c, "eff colour");
        // global off and disable both blank every output
        host.wr(LCB_ADDR_GLOBAL_SETTINGS, 8'h01);
        repeat (2) @(posedge core_clk);
        chk(eff_bright, '0, "forced off bright");
        chk(eff_color, '0, "forced off colour");
        host.wr(LCB_ADDR_GLOBAL_SETTINGS, 8'h00);
        repeat (2) @(posedge core_clk);
        chk(eff_bright, exp_b, "resumed");
        chk(eff_color, exp_c, "resumed colour");
        host.wr(LCB_ADDR_DEVICE_ENABLE_CTRL, 8'h00);
        repeat (2) @(posedge core_clk);
        chk(eff_bright, '0, "disabled bright");
        chk(eff_color, '0, "disabled colour");
        // a write while the clock enable is low is not taken
        clk_en <= 1'b0;
        host.wr(LCB_ADDR_GROUP_INTENSITY, 8'h01);
        clk_en <= 1'b1;
        rchk(LCB_ADDR_GROUP_INTENSITY, 8'h80);
        // a second reset in mid-run restores the reset values
        rst_b <= 1'b0;
        @(posedge core_clk);
        rst_b <= 1'b1;
        rchk(LCB_ADDR_GROUP_INTENSITY, rst_tab[3]);
        rchk(LCB_ADDR_GLOBAL_SETTINGS, rst_tab[1]);
        conclude();
    end
endmodule
